// File: inc/mode_setting_pkg.sv
// Constants and types for the mode-setting block of the DDR memory device
package mode_setting_pkg;

  localparam int ADDR_W = 13;
  localparam int COL_W = 12;

  localparam logic [1:0] BANK_BASE = 2'h0;
  localparam logic [1:0] BANK_EXT = 2'h1;

  localparam int BL_LSB = 0;
  localparam int BL_MSB = 2;
  localparam int BT_BIT = 3;
  localparam int CL_LSB = 4;
  localparam int CL_MSB = 6;
  localparam int DLL_RST_BIT = 8;
  localparam int MODE_LSB = 7;
  localparam int DLL_DIS_BIT = 0;
  localparam int DRIVE_BIT = 1;

  localparam logic [5:0] MODE_NORMAL = 6'h00;
  localparam logic [5:0] MODE_DLL_RESET = 6'h02;

  localparam logic [2:0] BL_CODE_2 = 3'h1;
  localparam logic [2:0] BL_CODE_4 = 3'h2;
  localparam logic [2:0] BL_CODE_8 = 3'h3;
  localparam logic [2:0] CL_CODE_2 = 3'h2;
  localparam logic [2:0] CL_CODE_3 = 3'h3;

  localparam logic [3:0] LEN_2 = 4'h2;
  localparam logic [3:0] LEN_4 = 4'h4;
  localparam logic [3:0] LEN_8 = 4'h8;
  localparam logic [3:0] LEN_NONE = 4'h0;

  // Latency 3 and 2: data at n + (latency-1) clocks
  localparam logic [2:0] LAT_DELAY_2 = 3'h1;
  localparam logic [2:0] LAT_DELAY_3 = 3'h2;

  localparam int DLL_LOCK_CYCLES = 200;

  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic cke;
  } command_s;

  typedef struct packed {
    logic [2:0] burst_len_code;
    logic burst_interleaved;
    logic [2:0] latency_code;
    logic dll_reset;
    logic [5:0] op_mode;
  } base_fields_s;

endpackage

// File: rtl/mode_setting_block.sv
// Mode-register load, burst column ordering and read-latency timing
`timescale 1ns/1ps
module mode_setting_block
#(
  parameter int COL_WIDTH = mode_setting_pkg::COL_W
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire mode_setting_pkg::command_s command,
  input wire logic [1:0] bank_select,
  input wire logic [mode_setting_pkg::ADDR_W-1:0] row_column_address_bus,
  input wire logic self_refresh_exit,
  input wire logic burst_start,
  input wire logic burst_is_read,
  input wire logic [COL_WIDTH-1:0] start_column,
  output logic [mode_setting_pkg::ADDR_W-1:0] base_mode_setting,
  output logic [mode_setting_pkg::ADDR_W-1:0] extended_mode_setting,
  output logic dll_enabled,
  output logic dll_reset_pulse,
  output logic reduced_drive,
  output logic normal_mode,
  output logic reserved_mode,
  output logic [3:0] burst_length,
  output logic burst_active,
  output logic burst_read,
  output logic [COL_WIDTH-1:0] burst_column,
  output logic read_data_valid
);

  // ----------------------------------------
  // Command decode
  // ----------------------------------------
  logic load_cmd;
  logic base_load;
  logic ext_load;
  mode_setting_pkg::base_fields_s base_f;

  assign load_cmd = command.cke & ~command.cs_n & ~command.ras_n
                    & ~command.cas_n & ~command.we_n;
  assign base_load = load_cmd & (bank_select == mode_setting_pkg::BANK_BASE);
  assign ext_load = load_cmd & (bank_select == mode_setting_pkg::BANK_EXT);
  assign base_f.burst_len_code =
    base_mode_setting[mode_setting_pkg::BL_MSB:mode_setting_pkg::BL_LSB];
  assign base_f.burst_interleaved = base_mode_setting[mode_setting_pkg::BT_BIT];
  assign base_f.latency_code =
    base_mode_setting[mode_setting_pkg::CL_MSB:mode_setting_pkg::CL_LSB];
  assign base_f.dll_reset = base_mode_setting[mode_setting_pkg::DLL_RST_BIT];
  assign base_f.op_mode =
    base_mode_setting[mode_setting_pkg::ADDR_W-1:mode_setting_pkg::MODE_LSB];

  // ----------------------------------------
  // Mode registers
  // ----------------------------------------
  // No defined power-up value exists; reset clears only for determinism
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      base_mode_setting <= '0;
    else if (base_load)
      base_mode_setting <= row_column_address_bus;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      extended_mode_setting <= '0;
    else if (ext_load)
      extended_mode_setting <= row_column_address_bus;
  end

  // ----------------------------------------
  // Operating mode and DLL control
  // ----------------------------------------
  logic [5:0] load_mode;
  assign load_mode = row_column_address_bus[mode_setting_pkg::ADDR_W-1:mode_setting_pkg::MODE_LSB];

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      normal_mode <= 1'b0;
      reserved_mode <= 1'b0;
      dll_reset_pulse <= 1'b0;
    end
    else
    begin
      dll_reset_pulse <= base_load && (load_mode == mode_setting_pkg::MODE_DLL_RESET);
      if (base_load)
      begin
        normal_mode <= (load_mode == mode_setting_pkg::MODE_NORMAL);
        reserved_mode <= (load_mode != mode_setting_pkg::MODE_NORMAL)
                         && (load_mode != mode_setting_pkg::MODE_DLL_RESET);
      end
    end
  end

  // Self refresh exit wins over a simultaneous load
  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      dll_enabled <= 1'b0;
    else if (self_refresh_exit)
      dll_enabled <= 1'b1;
    else if (ext_load)
      dll_enabled <= ~row_column_address_bus[mode_setting_pkg::DLL_DIS_BIT];
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      reduced_drive <= 1'b0;
    else if (ext_load)
      reduced_drive <= row_column_address_bus[mode_setting_pkg::DRIVE_BIT];
  end

  // ----------------------------------------
  // Burst length and latency decode
  // ----------------------------------------
  logic [3:0] len_dec;
  logic [2:0] lat_dec;

  always_comb
  begin
    unique case (base_f.burst_len_code)
      mode_setting_pkg::BL_CODE_2: len_dec = mode_setting_pkg::LEN_2;
      mode_setting_pkg::BL_CODE_4: len_dec = mode_setting_pkg::LEN_4;
      mode_setting_pkg::BL_CODE_8: len_dec = mode_setting_pkg::LEN_8;
      default: len_dec = mode_setting_pkg::LEN_NONE;
    endcase
  end

  always_comb
  begin
    unique case (base_f.latency_code)
      mode_setting_pkg::CL_CODE_2: lat_dec = mode_setting_pkg::LAT_DELAY_2;
      mode_setting_pkg::CL_CODE_3: lat_dec = mode_setting_pkg::LAT_DELAY_3;
      default: lat_dec = mode_setting_pkg::LAT_DELAY_3;
    endcase
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
      burst_length <= mode_setting_pkg::LEN_NONE;
    else
      burst_length <= len_dec;
  end

  // ----------------------------------------
  // Burst sequencer
  // ----------------------------------------
  logic [2:0] beat;
  logic [2:0] start_low;
  logic [2:0] len_mask;
  logic interleaved;
  logic [COL_WIDTH-1:0] block_base;
  logic [2:0] next_offset;
  logic [2:0] count_now;

  assign len_mask = 3'(len_dec - 4'h1);

  // Beat 0 is issued on the start edge; later beats from the running counter
  assign count_now = burst_start ? 3'h0 : beat;

  always_comb
  begin
    logic [2:0] s;
    s = burst_start ? start_column[2:0] : start_low;
    if (burst_start ? base_f.burst_interleaved : interleaved)
      next_offset = (s ^ count_now) & len_mask;
    else
      next_offset = 3'(s + count_now) & len_mask;
  end

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      burst_active <= 1'b0;
      burst_read <= 1'b0;
      beat <= 3'h0;
      start_low <= 3'h0;
      interleaved <= 1'b0;
      block_base <= '0;
      burst_column <= '0;
    end
    else if (burst_start && len_dec != mode_setting_pkg::LEN_NONE)
    begin
      burst_active <= 1'b1;
      burst_read <= burst_is_read;
      beat <= 3'h1;
      start_low <= start_column[2:0];
      interleaved <= base_f.burst_interleaved;
      block_base <= start_column & ~COL_WIDTH'(len_mask);
      burst_column <= (start_column & ~COL_WIDTH'(len_mask)) | COL_WIDTH'(next_offset);
    end
    // Beat wraps to zero after the last column, so a length of eight still ends
    else if (burst_active && beat != 3'h0)
    begin
      beat <= 3'(beat + 3'h1) & len_mask;
      burst_column <= block_base | COL_WIDTH'(next_offset);
    end
    else
      burst_active <= 1'b0;
  end

  // ----------------------------------------
  // Read latency timing
  // ----------------------------------------
  logic [2:0] lat_count;
  logic lat_run;

  always_ff @(posedge sys_clk or posedge reset)
  begin
    if (reset)
    begin
      lat_count <= 3'h0;
      lat_run <= 1'b0;
      read_data_valid <= 1'b0;
    end
    else
    begin
      read_data_valid <= 1'b0;
      if (burst_start && burst_is_read && len_dec != mode_setting_pkg::LEN_NONE)
      begin
        lat_run <= 1'b1;
        lat_count <= 3'(lat_dec - 3'h1);
        if (lat_dec == 3'h1)
        begin
          lat_run <= 1'b0;
          read_data_valid <= 1'b1;
        end
      end
      else if (lat_run)
      begin
        if (lat_count == 3'h1)
        begin
          lat_run <= 1'b0;
          read_data_valid <= 1'b1;
        end
        lat_count <= 3'(lat_count - 3'h1);
      end
    end
  end

endmodule

// File: tb/mode_setting_properties.sv
// Port-level assertions for the mode-setting block
`timescale 1ns/1ps
module mode_setting_properties
#(
  parameter int COL_WIDTH = 12
)
(
  input wire logic sys_clk,
  input wire logic reset,
  input wire mode_setting_pkg::command_s command,
  input wire logic [1:0] bank_select,
  input wire logic [mode_setting_pkg::ADDR_W-1:0] row_column_address_bus,
  input wire logic self_refresh_exit,
  input wire logic burst_start,
  input wire logic burst_is_read,
  input wire logic [COL_WIDTH-1:0] start_column,
  input wire logic [mode_setting_pkg::ADDR_W-1:0] base_mode_setting,
  input wire logic [mode_setting_pkg::ADDR_W-1:0] extended_mode_setting,
  input wire logic dll_enabled,
  input wire logic dll_reset_pulse,
  input wire logic reduced_drive,
  input wire logic normal_mode,
  input wire logic [3:0] burst_length,
  input wire logic burst_active,
  input wire logic [COL_WIDTH-1:0] burst_column,
  input wire logic read_data_valid
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  logic ld;
  logic [COL_WIDTH-4:0] blk;
  assign ld = command == 5'h01;
  assign blk = burst_column[COL_WIDTH-1:3];
  a_base_load: assert property (
    ld && bank_select == 2'h0 |=> base_mode_setting == $past(row_column_address_bus))
    else $error("base setting not loaded");
  a_ext_load: assert property (
    ld && bank_select == 2'h1 |=> extended_mode_setting == $past(row_column_address_bus))
    else $error("extended setting not loaded");
  a_bank_ignored: assert property (
    ld && bank_select[1] |=> $stable(base_mode_setting) && $stable(extended_mode_setting))
    else $error("load with upper bank changed a setting");
  a_dll_pulse: assert property (
    ld && bank_select == 2'h0 |=>
      dll_reset_pulse == ($past(row_column_address_bus[12:7]) == 6'h02))
    else $error("dll reset pulse wrong");
  a_normal_flag: assert property (
    ld && bank_select == 2'h0 |=> normal_mode == ($past(row_column_address_bus[12:7]) == 6'h00))
    else $error("normal mode flag wrong");
  a_ext_fields: assert property (
    ld && bank_select == 2'h1 && !self_refresh_exit |=> reduced_drive ==
      $past(row_column_address_bus[1]) && dll_enabled == !$past(row_column_address_bus[0]))
    else $error("extended fields wrong");
  a_srx_dll: assert property (self_refresh_exit |=> dll_enabled)
    else $error("dll not enabled after self refresh exit");
  a_first_col: assert property (
    burst_start && burst_length != 4'h0 |=> burst_active && burst_column == $past(start_column))
    else $error("first burst column wrong");
  a_block_wrap: assert property (
    burst_active && burst_length == 4'h8 && !$past(burst_start) |-> blk == $past(blk))
    else $error("burst left its block");
  a_len_eight: assert property (burst_start && burst_length == 4'h8 |=> burst_active [*8])
    else $error("burst of eight too short");
  a_read_lat: assert property (
    burst_start && burst_is_read && burst_length != 4'h0 && base_mode_setting[6:4] == 3'h3
      |=> ##1 (read_data_valid || $past(burst_start)))
    else $error("read data valid late");
endmodule
bind mode_setting_block mode_setting_properties #(.COL_WIDTH(COL_WIDTH)) u_props(.sys_clk,
  .reset, .command, .bank_select, .row_column_address_bus, .self_refresh_exit, .burst_start,
  .burst_is_read, .start_column, .base_mode_setting, .extended_mode_setting, .dll_enabled,
  .dll_reset_pulse, .reduced_drive, .normal_mode, .burst_length, .burst_active,
  .burst_column, .read_data_valid);

// File: tb/mem_ctrl_model.sv
// Memory controller model issuing setting loads
`timescale 1ns/1ps
module mem_ctrl_model
#(
  parameter int LOAD_GAP = 2
)
(
  input wire logic sys_clk,
  output mode_setting_pkg::command_s command,
  output logic [1:0] bank_select,
  output logic [mode_setting_pkg::ADDR_W-1:0] row_column_address_bus
);
  initial
  begin
    command = 5'h11;
    bank_select = 2'h3;
    row_column_address_bus = 13'h1fff;
  end
  task automatic load(input logic [1:0] bank, input logic [12:0] value);
    @(posedge sys_clk);
    command <= 5'h01;
    bank_select <= bank;
    row_column_address_bus <= value;
    @(posedge sys_clk);
    command <= 5'h11;
    // Released lines show the inverse, not the old opcode
    bank_select <= ~bank;
    row_column_address_bus <= ~value;
    repeat (LOAD_GAP) @(posedge sys_clk);
  endtask
  // Non-load command, such as refresh or precharge-all, on bank zero
  task automatic issue(input mode_setting_pkg::command_s cmd, input logic [12:0] value);
    @(posedge sys_clk);
    command <= cmd;
    bank_select <= 2'h0;
    row_column_address_bus <= value;
    @(posedge sys_clk);
    command <= 5'h11;
    bank_select <= 2'h3;
    row_column_address_bus <= ~value;
    repeat (LOAD_GAP) @(posedge sys_clk);
  endtask
endmodule

// File: tb/mode_setting_block_tb.sv
// Self-checking bench for the mode-setting block
`timescale 1ns/1ps
module mode_setting_block_tb;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic self_refresh_exit = 1'b0;
  logic burst_start = 1'b0;
  logic burst_is_read = 1'b0;
  logic [11:0] start_column = 12'h000;
  mode_setting_pkg::command_s command;
  logic [1:0] bank_select;
  logic [12:0] row_column_address_bus, base_mode_setting, extended_mode_setting;
  logic dll_enabled, dll_reset_pulse, reduced_drive, normal_mode, reserved_mode;
  logic burst_active, burst_read, read_data_valid;
  logic [3:0] burst_length;
  logic [11:0] burst_column;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  always #4 sys_clk = ~sys_clk;
  mem_ctrl_model u_ctrl(.sys_clk, .command, .bank_select, .row_column_address_bus);
  mode_setting_block u_dut(.sys_clk, .reset, .command, .bank_select, .row_column_address_bus,
    .self_refresh_exit, .burst_start, .burst_is_read, .start_column, .base_mode_setting,
    .extended_mode_setting, .dll_enabled, .dll_reset_pulse, .reduced_drive, .normal_mode,
    .reserved_mode, .burst_length, .burst_active, .burst_read, .burst_column,
    .read_data_valid);
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("errors=%0d checks=%0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_base;
    u_ctrl.load(2'h0, 13'h0132);
    chk(base_mode_setting, 13'h0132);
    chk({9'h0, burst_length}, 13'h4);
    u_ctrl.load(2'h0, 13'h0032);
    chk({11'h0, normal_mode, reserved_mode}, 13'h2);
    u_ctrl.load(2'h0, 13'h0432);
    chk({11'h0, normal_mode, reserved_mode}, 13'h1);
  endtask
  task automatic t_ext;
    u_ctrl.load(2'h1, 13'h0003);
    chk(extended_mode_setting, 13'h0003);
    chk({11'h0, reduced_drive, dll_enabled}, 13'h2);
    u_ctrl.load(2'h2, 13'h0000);
    u_ctrl.load(2'h3, 13'h0000);
    chk(extended_mode_setting, 13'h0003);
    @(posedge sys_clk) self_refresh_exit <= 1'b1;
    @(posedge sys_clk) self_refresh_exit <= 1'b0;
    #1 chk({12'h0, dll_enabled}, 13'h1);
    u_ctrl.load(2'h1, 13'h0000);
    chk({11'h0, reduced_drive, dll_enabled}, 13'h1);
    u_ctrl.load(2'h0, 13'h0132);
    u_ctrl.issue(5'h03, 13'h0000);
    u_ctrl.issue(5'h03, 13'h0000);
    u_ctrl.issue(5'h05, 13'h0400);
    chk(base_mode_setting, 13'h0132);
    repeat (200) @(posedge sys_clk);
  endtask
  task automatic t_burst(input logic [2:0] code, input logic il, input logic [11:0] s,
      input logic rd, input logic [2:0] cl);
    logic [11:0] len;
    logic [11:0] exp;
    len = 12'h1 << code;
    u_ctrl.load(2'h0, {6'h00, cl, il, code});
    @(posedge sys_clk);
    burst_start <= 1'b1;
    burst_is_read <= rd;
    start_column <= s;
    @(posedge sys_clk);
    burst_start <= 1'b0;
    start_column <= ~s;
    for (int k = 0; k < len; k++)
    begin
      #1;
      exp = (s & ~(len - 12'h1)) | ((il ? (s ^ k) : (s + k)) & (len - 12'h1));
      chk({1'b0, burst_column}, {1'b0, exp});
      chk({11'h0, burst_active, burst_read}, {11'h0, 1'b1, rd});
      if (rd)
        chk({12'h0, read_data_valid}, {12'h0, k == cl - 3'h2});
      @(posedge sys_clk);
    end
    #1 chk({12'h0, burst_active}, 13'h0);
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      err_total++;
      end_of_test;
    end
  end
  initial
  begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_base;
    t_ext;
    t_burst(3'h1, 1'b0, 12'h3a1, 1'b0, 3'h3);
    t_burst(3'h1, 1'b1, 12'h3a1, 1'b1, 3'h2);
    t_burst(3'h2, 1'b0, 12'h005, 1'b1, 3'h3);
    t_burst(3'h2, 1'b1, 12'h005, 1'b1, 3'h2);
    t_burst(3'h3, 1'b0, 12'h7fd, 1'b0, 3'h3);
    t_burst(3'h3, 1'b1, 12'h2a5, 1'b1, 3'h3);
    end_of_test;
  end
endmodule
